// ==== logic/fdh_top.sv ====
// Fail-safe input discrepancy handler with AHB-Lite register access
//
// Added by the designer: the address map and the AHB-Lite register port.
`timescale 1ns/1ns
`default_nettype none

//////////////////////////////////////////////////////////////////////////////////////////////////

// Contract
// - Discrepancy under torque-off keeps torque-off active
// - Discrepancy under stop-one carries out stop-one
// - Basic response in three basic configurations
// - Basic: fault after tolerance, code per channel
// - Basic: set internal event, status bit 7
// - Terminals: clear event by high-low-high input
// - Safety word: bit0/bit1 high-low-high clears event
// - Safety word: bit7 low-high-low acknowledges
// - Restart only after run low then high
// - Extended response when extended on terminals
// - Extended: never flag internal event
// - Extended: fault after tolerance, code per channel
// - Extended: clear by low-high-low acknowledge pulse
// - Detected discrepancy forces input to zero
// - Input stays safe until acknowledge or reset
module fdh_top
    import fdh_pkg::*;
#(
    parameter int TOL_W = 16
) (
    input  wire logic        hclk,
    input  wire logic        hresetn,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic             hreadyout,
    output logic             hresp,
    output logic      [31:0] hrdata,
    input  wire logic        fsin_ch_a,
    input  wire logic        fsin_ch_b,
    input  wire logic        fs_ack_in,
    output logic             torque_off_active,
    output logic             stop_one_active,
    output logic             motor_on,
    output logic             internal_event,
    output logic      [3:0]  disc_fault
);

    import fdh_pkg::*;

    //////////////////////////////////////////////////////////////////////////////////////////////

    typedef struct packed
    {
        logic             wr_pend;
        logic [7:0]       wr_addr;
        logic [31:0]      rdata;
        fdh_mode_t        mode;
        logic             fsel;
        logic [7:0]       cw;
        logic             run;
        logic [TOL_W-1:0] tol;
        logic [TOL_W-1:0] cnt;
        logic             disc;
        logic             ie;
        logic [3:0]       fault;
        logic             in_low;
        logic             ps0_low;
        logic             ps1_low;
        logic             ps7_high;
        logic             ack_high;
        logic             std_pend;
        logic             armed;
        logic             motor;
        logic             toff;
        logic             sone;
    } fdh_st_t;

    fdh_st_t    st_r;
    fdh_st_t    st_nxt;
    logic [2:0] pins_sync;
    logic       ch_a;
    logic       ch_b;
    logic       ack_s;

    //////////////////////////////////////////////////////////////////////////////////////////////

    fdh_sync #(
        .WIDTH (3)
    ) u_sync (
        .hclk     (hclk),
        .hresetn  (hresetn),
        .async_in ({fs_ack_in, fsin_ch_b, fsin_ch_a}),
        .sync_out (pins_sync)
    );

    assign ch_a  = pins_sync[0];
    assign ch_b  = pins_sync[1];
    assign ack_s = pins_sync[2];

    //////////////////////////////////////////////////////////////////////////////////////////////

    always_comb
    begin
        logic       addr_ok;
        logic       do_wr;
        logic       basic;
        logic       ps_used;
        logic       equal;
        logic       both_hi;
        logic       both_lo;
        logic       detect;
        logic       clr;
        logic       sel;
        logic       std_ack;
        logic       blocked;
        logic [1:0] flt_idx;
        logic [31:0] rd;

        addr_ok = 1'b0;
        do_wr   = 1'b0;
        basic   = 1'b0;
        ps_used = 1'b0;
        equal   = 1'b0;
        both_hi = 1'b0;
        both_lo = 1'b0;
        detect  = 1'b0;
        clr     = 1'b0;
        sel     = 1'b0;
        std_ack = 1'b0;
        blocked = 1'b0;
        flt_idx = 2'h0;
        rd      = 32'h0000_0000;
        st_nxt  = st_r;

        // Bus write lands in the data phase, one cycle after its address phase
        do_wr   = st_r.wr_pend;
        addr_ok = hsel && hready && (htrans == FDH_HTRANS_NONSEQ);
        st_nxt.wr_pend = addr_ok && hwrite;
        if (addr_ok)
        begin
            st_nxt.wr_addr = haddr[7:0];
        end

        if (do_wr)
        begin
            unique case (st_r.wr_addr)
                FDH_CFG_OFS:
                begin
                    st_nxt.mode = fdh_mode_t'(hwdata[FDH_CFG_MODE_LSB +: 2]);
                    st_nxt.fsel = hwdata[FDH_CFG_FSEL_BIT];
                end
                FDH_PSCW_OFS:
                begin
                    st_nxt.cw = hwdata[7:0];
                end
                FDH_DRV_OFS:
                begin
                    st_nxt.run = hwdata[FDH_DRV_RUN_BIT];
                    std_ack    = hwdata[FDH_DRV_SACK_BIT];
                end
                FDH_TOL_OFS:
                begin
                    st_nxt.tol = hwdata[TOL_W-1:0];
                end
                default:
                begin
                    // Read-only and unmapped words ignore writes
                end
            endcase
        end

        // Configuration decides which response applies
        basic   = (st_r.mode != FDH_MODE_EXT_TERM);
        ps_used = (st_r.mode == FDH_MODE_BASIC_PS_TERM)
                  || (st_r.mode == FDH_MODE_EXT_PS_BASIC_TERM);

        equal   = (ch_a == ch_b);
        both_hi = ch_a && ch_b;
        both_lo = !ch_a && !ch_b;

        // Mismatch must persist past the tolerance; any agreement restarts the count
        if (equal || st_r.disc)
        begin
            st_nxt.cnt = '0;
        end
        else if (st_r.cnt >= st_r.tol)
        begin
            detect = 1'b1;
        end
        else
        begin
            st_nxt.cnt = st_r.cnt + 1'b1;
        end

        // The channel reading low is taken as the broken one
        flt_idx = basic ? 2'(FDH_FLT_BASIC_CH1) : 2'(FDH_FLT_EXT_CH1);
        flt_idx = flt_idx + {1'b0, ch_a};

        // Sequence trackers, armed only while a discrepancy is latched
        if (st_r.disc)
        begin
            if (both_lo)
            begin
                st_nxt.in_low = 1'b1;
            end
            if (!st_r.cw[FDH_CW_TOFF_BIT])
            begin
                st_nxt.ps0_low = 1'b1;
            end
            if (!st_r.cw[FDH_CW_SONE_BIT])
            begin
                st_nxt.ps1_low = 1'b1;
            end
            if (st_r.cw[FDH_CW_ACK_BIT])
            begin
                st_nxt.ps7_high = 1'b1;
            end
            if (ack_s)
            begin
                st_nxt.ack_high = 1'b1;
            end
        end

        // Acknowledge counts only once the two channels agree again
        if (st_r.disc && equal)
        begin
            if (basic)
            begin
                clr = st_r.in_low && both_hi;
                if (ps_used)
                begin
                    clr = clr
                          || (st_r.ps0_low && st_r.cw[FDH_CW_TOFF_BIT])
                          || (st_r.ps1_low && st_r.cw[FDH_CW_SONE_BIT]);
                    clr = clr || (st_r.ps7_high && !st_r.cw[FDH_CW_ACK_BIT]);
                end
            end
            else
            begin
                clr = st_r.ack_high && !ack_s;
            end
        end

        if (detect)
        begin
            st_nxt.disc            = 1'b1;
            st_nxt.fault[flt_idx]  = 1'b1;
            st_nxt.ie              = basic;
            st_nxt.in_low          = 1'b0;
            st_nxt.ps0_low         = 1'b0;
            st_nxt.ps1_low         = 1'b0;
            st_nxt.ps7_high        = 1'b0;
            st_nxt.ack_high        = 1'b0;
        end
        else if (clr)
        begin
            st_nxt.disc     = 1'b0;
            st_nxt.ie       = 1'b0;
            st_nxt.fault    = 4'h0;
            st_nxt.in_low   = 1'b0;
            st_nxt.ps0_low  = 1'b0;
            st_nxt.ps1_low  = 1'b0;
            st_nxt.ps7_high = 1'b0;
            st_nxt.ack_high = 1'b0;
        end

        // After a fail-safe acknowledge the standard acknowledge is still owed
        if (clr)
        begin
            st_nxt.std_pend = 1'b1;
        end
        else if (std_ack)
        begin
            st_nxt.std_pend = 1'b0;
        end

        // A latched discrepancy reads as zero, which selects the configured function
        sel = st_r.disc || !both_hi;
        st_nxt.toff = (sel && !st_r.fsel)
                      || (ps_used && !st_r.cw[FDH_CW_TOFF_BIT]);
        st_nxt.sone = (sel && st_r.fsel)
                      || (ps_used && !st_r.cw[FDH_CW_SONE_BIT]);

        // Restart needs a fresh low on the run command once nothing blocks it
        // Judged on next-state values so the motor drops on the edge the block appears
        blocked = st_nxt.toff || st_nxt.sone || st_nxt.disc || st_nxt.ie || st_nxt.std_pend;
        if (blocked)
        begin
            st_nxt.armed = 1'b0;
            st_nxt.motor = 1'b0;
        end
        else
        begin
            if (!st_r.run)
            begin
                st_nxt.armed = 1'b1;
            end
            st_nxt.motor = st_r.run && (st_r.armed || st_r.motor);
        end

        // Read data is captured in the address phase and shown in the data phase
        if (addr_ok && !hwrite)
        begin
            unique case (haddr[7:0])
                FDH_CFG_OFS:
                begin
                    rd[FDH_CFG_MODE_LSB +: 2] = st_r.mode;
                    rd[FDH_CFG_FSEL_BIT]      = st_r.fsel;
                end
                FDH_PSCW_OFS:
                begin
                    rd[7:0] = st_r.cw;
                end
                FDH_DRV_OFS:
                begin
                    rd[FDH_DRV_RUN_BIT] = st_r.run;
                end
                FDH_TOL_OFS:
                begin
                    rd[TOL_W-1:0] = st_r.tol;
                end
                FDH_STAT_OFS:
                begin
                    rd[FDH_ST_FAULT_LSB +: 4] = st_r.fault;
                    rd[FDH_ST_SAFE_BIT]       = st_r.disc;
                    rd[FDH_ST_TOFF_BIT]       = st_r.toff;
                    rd[FDH_ST_SONE_BIT]       = st_r.sone;
                    rd[FDH_ST_MOTOR_BIT]      = st_r.motor;
                    rd[FDH_ST_SACK_BIT]       = st_r.std_pend;
                end
                FDH_PSSW_OFS:
                begin
                    rd[FDH_SW_IEV_BIT] = st_r.ie;
                end
                default:
                begin
                    rd = 32'h0000_0000;
                end
            endcase
            st_nxt.rdata = rd;
        end
    end

    //////////////////////////////////////////////////////////////////////////////////////////////

    // Power-on reset is the only way out besides a valid acknowledge sequence
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            st_r      <= '0;
            st_r.mode <= fdh_mode_t'(FDH_CFG_MODE_RST);
            st_r.fsel <= FDH_CFG_FSEL_RST;
            st_r.cw   <= FDH_PSCW_RST;
            st_r.tol  <= FDH_TOL_RST[TOL_W-1:0];
            st_r.toff <= 1'b1;
            st_r.sone <= 1'b0;
        end
        else
        begin
            st_r <= st_nxt;
        end
    end

    //////////////////////////////////////////////////////////////////////////////////////////////

    assign hreadyout         = 1'b1;
    assign hresp             = 1'b0;
    assign hrdata            = st_r.rdata;
    assign torque_off_active = st_r.toff;
    assign stop_one_active   = st_r.sone;
    assign motor_on          = st_r.motor;
    assign internal_event    = st_r.ie;
    assign disc_fault        = st_r.fault;

endmodule

`default_nettype wire

// ==== logic/fdh_pkg.sv ====
// Package: register map, field positions, reset values and modes of the discrepancy handler
package fdh_pkg;

    // Register byte offsets
    localparam logic [7:0] FDH_CFG_OFS    = 8'h00;
    localparam logic [7:0] FDH_PSCW_OFS   = 8'h04;
    localparam logic [7:0] FDH_DRV_OFS    = 8'h08;
    localparam logic [7:0] FDH_TOL_OFS    = 8'h0C;
    localparam logic [7:0] FDH_STAT_OFS   = 8'h10;
    localparam logic [7:0] FDH_PSSW_OFS   = 8'h14;

    // Configuration register fields
    localparam int FDH_CFG_MODE_LSB  = 0;
    localparam int FDH_CFG_FSEL_BIT  = 2;

    // Safety control word 1 fields
    localparam int FDH_CW_TOFF_BIT   = 0;
    localparam int FDH_CW_SONE_BIT   = 1;
    localparam int FDH_CW_ACK_BIT    = 7;

    // Drive control register fields
    localparam int FDH_DRV_RUN_BIT   = 0;
    localparam int FDH_DRV_SACK_BIT  = 1;

    // Status register fields
    localparam int FDH_ST_FAULT_LSB  = 0;
    localparam int FDH_ST_SAFE_BIT   = 4;
    localparam int FDH_ST_TOFF_BIT   = 5;
    localparam int FDH_ST_SONE_BIT   = 6;
    localparam int FDH_ST_MOTOR_BIT  = 7;
    localparam int FDH_ST_SACK_BIT   = 8;

    // Safety status word 1: internal event flag
    localparam int FDH_SW_IEV_BIT    = 7;

    // Fault vector index: basic codes 0/1, extended codes 2/3, one per processing channel
    localparam int FDH_FLT_BASIC_CH1 = 0;
    localparam int FDH_FLT_EXT_CH1   = 2;

    // Reset values
    localparam logic [1:0]  FDH_CFG_MODE_RST = 2'h0;
    localparam logic        FDH_CFG_FSEL_RST = 1'b0;
    localparam logic [7:0]  FDH_PSCW_RST     = 8'h03;
    localparam logic [15:0] FDH_TOL_RST      = 16'h01F4;

    // AHB transfer type
    localparam logic [1:0]  FDH_HTRANS_NONSEQ = 2'h2;

    // Function configurations
    typedef enum logic [1:0]
    {
        FDH_MODE_BASIC_TERM,
        FDH_MODE_BASIC_PS_TERM,
        FDH_MODE_EXT_PS_BASIC_TERM,
        FDH_MODE_EXT_TERM
    } fdh_mode_t;

endpackage

// ==== logic/fdh_sync.sv ====
// Two-stage synchroniser for a vector of asynchronous pin inputs
`timescale 1ns/1ns
`default_nettype none

module fdh_sync #(
    parameter int WIDTH = 3
) (
    input  wire logic             hclk,
    input  wire logic             hresetn,
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] sync_out
);

    typedef struct packed
    {
        logic [WIDTH-1:0] meta;
        logic [WIDTH-1:0] stable;
    } fdh_sync_st_t;

    fdh_sync_st_t st_r;
    fdh_sync_st_t st_nxt;

    always_comb
    begin
        st_nxt        = st_r;
        st_nxt.meta   = async_in;
        st_nxt.stable = st_r.meta;
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            st_r <= '0;
        end
        else
        begin
            st_r <= st_nxt;
        end
    end

    assign sync_out = st_r.stable;

endmodule

`default_nettype wire

// ==== tb/fdh_top_sva.sv ====
// Checker: port-level properties of the discrepancy handler
`timescale 1ns/1ns
`default_nettype none

module fdh_top_sva (
    input wire logic       hclk,
    input wire logic       hresetn,
    input wire logic       fsin_ch_a,
    input wire logic       fsin_ch_b,
    input wire logic       torque_off_active,
    input wire logic       stop_one_active,
    input wire logic       motor_on,
    input wire logic       internal_event,
    input wire logic [3:0] disc_fault
);
    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);

//////////////////////////////////////////////////////////////////////////////////////////////////

    one_code_a: assert property ($onehot0(disc_fault))
        else $error("more than one discrepancy code raised");
    ext_no_event_a: assert property (|disc_fault[3:2] |-> !internal_event)
        else $error("internal event beside an extended fault");
    event_basic_a: assert property ($rose(internal_event) |-> $rose(|disc_fault[1:0]))
        else $error("internal event without a basic fault");
    // Pins reach the logic two flops late, so the mismatch is looked at three edges back
    needs_mismatch_a: assert property
        ($rose(|disc_fault) |-> $past(fsin_ch_a != fsin_ch_b, 3))
        else $error("fault raised without a channel mismatch");
    safe_held_a: assert property
        ($rose(|disc_fault) |-> ##1 (torque_off_active || stop_one_active)[*3])
        else $error("no safety function after discrepancy");
    torque_blocks_a: assert property (torque_off_active |-> !motor_on)
        else $error("motor on under torque off");
    stop_blocks_a: assert property (stop_one_active |-> !motor_on)
        else $error("motor on under stop one");
    fault_blocks_a: assert property ((|disc_fault || internal_event) |-> !motor_on)
        else $error("motor on while fault or event stands");
    ext_clear_a: assert property
        ($fell(|disc_fault[3:2]) |-> $past(fsin_ch_a == fsin_ch_b, 3))
        else $error("extended fault cleared while channels disagree");

    restart_c: cover property ($rose(motor_on));
    event_c: cover property ($rose(internal_event));
    ext_clear_c: cover property ($fell(disc_fault[3]));
    chan_a_c: cover property ($rose(disc_fault[2]));
endmodule

bind fdh_top fdh_top_sva i_sva (
    .hclk              (hclk),
    .hresetn           (hresetn),
    .fsin_ch_a         (fsin_ch_a),
    .fsin_ch_b         (fsin_ch_b),
    .torque_off_active (torque_off_active),
    .stop_one_active   (stop_one_active),
    .motor_on          (motor_on),
    .internal_event    (internal_event),
    .disc_fault        (disc_fault)
);

`default_nettype wire

// ==== tb/fdh_ctrl_model.sv ====
// Partner: safety controller wiring that drives the redundant input and acknowledge pins
`timescale 1ns/1ns
`default_nettype none

module fdh_ctrl_model (
    input  wire logic hclk,
    input  wire logic sel_n,
    input  wire logic cut_a,
    input  wire logic cut_b,
    input  wire logic ack_req,
    output var logic  fsin_ch_a,
    output var logic  fsin_ch_b,
    output var logic  fs_ack_in
);
    initial {fsin_ch_a, fsin_ch_b, fs_ack_in} = 3'b110;

    // A cut wire reads low, as a broken line would
    always @(posedge hclk)
    begin
        fsin_ch_a <= sel_n & ~cut_a;
        fsin_ch_b <= sel_n & ~cut_b;
        // Acknowledge only once the wiring fault is gone
        fs_ack_in <= ack_req & ~cut_a & ~cut_b;
    end
endmodule

`default_nettype wire

// ==== tb/testbench.sv ====
// Testbench: register and pin sequences for the discrepancy handler
`timescale 1ns/1ns
`default_nettype none
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin fails++; \
    $display("[ERR] t=%0t got=%h exp=%h", $time, g, e); end end

module testbench;
    import fdh_pkg::*;
    logic        hclk = 1'b0;
    logic        hresetn = 1'b0;
    logic        hsel = 1'b0;
    logic        hwrite = 1'b0;
    logic [1:0]  htrans = 2'h0;
    logic [31:0] haddr = 32'h0;
    logic [31:0] hwdata = 32'h0;
    logic        sel_n = 1'b1;
    logic        cut_b = 1'b0;
    logic        cut_a = 1'b0;
    logic        ack_req = 1'b0;
    logic        hready, hreadyout, hresp, fa, fb, fk;
    logic        toff, sone, motor, iev, fsel;
    logic [3:0]  dflt;
    logic [31:0] hrdata, rd;
    int          fails = 0;
    int          n_tests = 0;

    always #5 hclk = ~hclk;
    assign hready = hreadyout;

    fdh_ctrl_model i_ctrl (.hclk(hclk), .sel_n(sel_n), .cut_a(cut_a), .cut_b(cut_b),
        .ack_req(ack_req), .fsin_ch_a(fa), .fsin_ch_b(fb), .fs_ack_in(fk));
    fdh_top i_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hready),
        .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .fsin_ch_a(fa), .fsin_ch_b(fb),
        .fs_ack_in(fk), .torque_off_active(toff), .stop_one_active(sone), .motor_on(motor),
        .internal_event(iev), .disc_fault(dflt));

//////////////////////////////////////////////////////////////////////////////////////////////////

    // Outputs are looked at 1 ns after the edge so the design's updates have landed
    task automatic wt(input int n);
        repeat (n) @(posedge hclk);
        #1;
    endtask

    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge hclk);
        hsel <= 1'b1;
        htrans <= FDH_HTRANS_NONSEQ;
        haddr <= {24'h0, a};
        hwrite <= w;
        do @(posedge hclk); while (hready !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge hclk); while (hready !== 1'b1);
        rd = hrdata;
        `CHK(hresp, 1'b0)
    endtask

    task automatic rchk(input logic [7:0] a, input logic [31:0] e);
        bus(1'b0, a, 32'h0);
        `CHK(rd, e)
    endtask

    task automatic pulse(input logic ack);
        @(posedge hclk);
        if (ack) ack_req <= 1'b1;
        else sel_n <= 1'b0;
        wt(5);
        @(posedge hclk);
        ack_req <= 1'b0;
        sel_n <= 1'b1;
        wt(6);
    endtask

    task automatic cut(input logic v);
        @(posedge hclk);
        cut_b <= v;
        wt(12);
    endtask

    task automatic restart();
        bus(1'b1, FDH_DRV_OFS, 32'h0);
        bus(1'b1, FDH_DRV_OFS, 32'h1);
        wt(3);
        `CHK(motor, 1'b0)
        bus(1'b1, FDH_DRV_OFS, 32'h3);
        wt(3);
        `CHK(motor, 1'b0)
        bus(1'b1, FDH_DRV_OFS, 32'h0);
        bus(1'b1, FDH_DRV_OFS, 32'h1);
        wt(3);
        `CHK(motor, 1'b1)
    endtask

    task automatic results();
        $display("n_tests=%0d fails=%0d", n_tests, fails);
        if (fails == 0 && n_tests > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    initial
    begin
        repeat (6000) @(posedge hclk);
        fails++;
        results();
    end

    initial
    begin
        wt(2);
        `CHK(toff, 1'b1)
        repeat (14) @(posedge hclk);
        hresetn <= 1'b1;
        rchk(FDH_CFG_OFS, 32'h0);
        rchk(FDH_PSCW_OFS, 32'h3);
        rchk(FDH_TOL_OFS, 32'h1F4);
        rchk(8'h18, 32'h0);
        bus(1'b1, FDH_STAT_OFS, 32'hFFFF);
        rchk(FDH_STAT_OFS, 32'h0);
        bus(1'b1, FDH_TOL_OFS, 32'h2);
        rchk(FDH_TOL_OFS, 32'h2);
        @(posedge hclk);
        cut_b <= 1'b1;
        wt(1);
        @(posedge hclk);
        cut_b <= 1'b0;
        wt(8);
        `CHK(dflt, 4'h0)
        // Basic configurations, each cleared by a different sequence
        for (int m = 0; m < 3; m++)
        begin
            fsel = (m == 1);
            bus(1'b1, FDH_CFG_OFS, {29'h0, fsel, m[1:0]});
            cut(1'b1);
            `CHK(dflt, 4'h2)
            `CHK(iev, 1'b1)
            `CHK(fsel ? sone : toff, 1'b1)
            rchk(FDH_PSSW_OFS, 32'h80);
            bus(1'b0, FDH_STAT_OFS, 32'h0);
            `CHK(rd[4:0], 5'h12)
            cut(1'b0);
            pulse(1'b1);
            `CHK(iev, 1'b1)
            `CHK(dflt, 4'h2)
            if (m == 0) pulse(1'b0);
            else if (m == 1) bus(1'b1, FDH_PSCW_OFS, 32'h2);
            else bus(1'b1, FDH_PSCW_OFS, 32'h83);
            bus(1'b1, FDH_PSCW_OFS, 32'h3);
            wt(4);
            `CHK({iev, dflt}, 5'h0)
            restart();
        end
        // Extended configuration on terminals
        bus(1'b1, FDH_CFG_OFS, 32'h3);
        cut(1'b1);
        `CHK(dflt, 4'h8)
        `CHK(iev, 1'b0)
        `CHK({toff, motor}, 2'h2)
        cut(1'b0);
        pulse(1'b0);
        `CHK(dflt, 4'h8)
        pulse(1'b1);
        `CHK(dflt, 4'h0)
        restart();
        // A break on channel a raises the other code of the pair
        @(posedge hclk);
        cut_a <= 1'b1;
        wt(12);
        `CHK({toff, motor, dflt}, 6'h24)
        @(posedge hclk);
        cut_a <= 1'b0;
        wt(12);
        pulse(1'b1);
        `CHK(dflt, 4'h0)
        // Power-on reset also clears a standing fault
        cut(1'b1);
        `CHK(dflt, 4'h8)
        @(posedge hclk);
        hresetn <= 1'b0;
        wt(2);
        `CHK({toff, dflt}, 5'h10)
        @(posedge hclk);
        hresetn <= 1'b1;
        cut_b <= 1'b0;
        wt(8);
        `CHK({toff, dflt}, 5'h00)
        results();
    end
endmodule

`default_nettype wire
